// file: keypad_pkg.sv
// Shared constants for the front-panel parameter-matrix entry block.
// Assumes a single 40 MHz clock and a classic Wishbone register port.
package keypad_pkg;

    // Clock and flash timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int unsigned FLASH_CNT_W = 24;

    // Matrix geometry
    localparam int unsigned NUM_FIELDS = 100;
    localparam logic [3:0] LAST_INDEX = 4'h9;
    localparam logic [3:0] NUM_COLS = 4'hA;
    localparam logic [1:0] LAST_DIGIT = 2'h3;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] RESET_ROW = 4'h9;
    localparam logic [3:0] RESET_COL = 4'h5;
    localparam logic [13:0] RESET_LO = 14'h029E;
    localparam logic [13:0] RESET_HI = 14'h02A7;

    // Field word: [15:0] four digits, leftmost in [15:12], [16] minus, [18:17] point
    localparam int unsigned FIELD_W = 19;
    localparam int unsigned FLD_NEG = 16;
    localparam int unsigned FLD_DP_LSB = 17;
    localparam logic [18:0] FACTORY_DEFAULT = 19'h00000;

    // Address switch bank
    localparam int unsigned SW_COUNT = 6;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FIELD_SEL = 8'h08;
    localparam logic [7:0] OFS_FIELD_DATA = 8'h0C;
    localparam logic [7:0] OFS_TAG = 8'h10;

    // Control layout: [0] lock, [25:16] read-only row mask
    localparam int unsigned CTRL_LOCK = 0;
    localparam int unsigned CTRL_RO_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0001_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h03FF_0001;
    localparam logic [31:0] TAG_RESET = 32'h0000_0000;
    localparam logic [6:0] FIELD_SEL_RESET = 7'h00;

    // Key vector positions
    localparam int unsigned KEY_COUNT = 6;
    localparam int unsigned K_ROW = 0;
    localparam int unsigned K_COL = 1;
    localparam int unsigned K_RIGHT = 2;
    localparam int unsigned K_INC = 3;
    localparam int unsigned K_DEC = 4;
    localparam int unsigned K_ENTER = 5;

    typedef enum logic [0:0] {
        EDIT_IDLE = 1'b0,
        EDIT_ACTIVE = 1'b1
    } edit_state_t;

endpackage

// file: key_press.sv
// Press detector for a vector of front-panel keys.
// Keys are synchronous to clk_i and already debounced.
`timescale 1ns/1ps
module key_press #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] key_i,
    output logic [WIDTH-1:0] press_o
);

    logic [WIDTH-1:0] level_q;

    // Previous level, so a held key yields one press only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_q <= '0;
        end else begin
            level_q <= key_i;
        end
    end

    assign press_o = key_i & ~level_q;

endmodule

// file: keypad_entry.sv
// Front-panel matrix navigation, digit entry and local/remote arbitration.
// Assumes debounced keys synchronous to clk_i and a classic Wishbone master.
`timescale 1ns/1ps
module keypad_entry #(
    parameter int unsigned FLASH_HALF_CYCLES = keypad_pkg::FLASH_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic key_row_i,
    input wire logic key_col_i,
    input wire logic key_right_i,
    input wire logic key_inc_i,
    input wire logic key_dec_i,
    input wire logic key_enter_i,
    input wire logic [5:0] addr_switch_i,
    input wire logic terminal_present_i,
    output logic [3:0] row_o,
    output logic [3:0] col_o,
    output logic [1:0] cursor_o,
    output logic editing_o,
    output logic [15:0] value_digits_o,
    output logic minus_o,
    output logic [1:0] dp_o,
    output logic blink_o,
    output logic local_mode_o,
    output logic [5:0] dev_addr_o,
    output logic factory_reload_o
);

    localparam int unsigned FW = keypad_pkg::FIELD_W;

    logic [keypad_pkg::KEY_COUNT-1:0] keys;
    logic [keypad_pkg::KEY_COUNT-1:0] press;
    logic [3:0] row_q;
    logic [3:0] col_q;
    logic [1:0] cursor_q;
    logic [FW-1:0] edit_q;
    keypad_pkg::edit_state_t state_q;
    logic [FW-1:0] field_q [0:keypad_pkg::NUM_FIELDS-1];
    logic [31:0] ctrl_q;
    logic [31:0] tag_q;
    logic [6:0] field_sel_q;
    logic local_q;
    logic [5:0] addr_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [keypad_pkg::FLASH_CNT_W-1:0] flash_cnt_q;
    logic phase_q;
    logic blink_q;
    logic reload_q;
    logic [FW-1:0] shown_q;

    logic [6:0] cur_idx;
    logic [3:0] cur_digit;
    logic [3:0] digit_lsb;
    logic lock;
    logic editable;
    logic jump;
    logic navigate;
    logic dp_combo;
    logic commit;
    logic [13:0] magnitude;
    logic reset_value;
    logic bus_take;
    logic bus_write;
    logic remote_ok;
    logic [31:0] status_word;
    logic [31:0] field_word;

    assign keys = {key_enter_i, key_dec_i, key_inc_i, key_right_i, key_col_i, key_row_i};

    key_press #(
        .WIDTH(keypad_pkg::KEY_COUNT)
    ) u_keys (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .key_i(keys),
        .press_o(press)
    );

    // Matrix position to storage index
    assign cur_idx = 7'(row_q) * 7'(keypad_pkg::NUM_COLS) + {3'h0, col_q};
    assign lock = ctrl_q[keypad_pkg::CTRL_LOCK];
    // Read-only rows and the lock both make a field steady and refuse edits
    assign editable = ~lock & ~ctrl_q[keypad_pkg::CTRL_RO_LSB + 32'(row_q)];

    // Key decoding; a combined press must not also act as its single key
    assign jump = (press[keypad_pkg::K_ROW] & key_col_i)
                | (press[keypad_pkg::K_COL] & key_row_i);
    assign navigate = press[keypad_pkg::K_ROW] | press[keypad_pkg::K_COL];
    assign dp_combo = (press[keypad_pkg::K_RIGHT] & key_inc_i)
                    | (press[keypad_pkg::K_INC] & key_right_i);

    // Cursor 0 is the leftmost digit, which sits in the top nibble
    assign digit_lsb = {~cursor_q, 2'b00};
    assign cur_digit = edit_q[digit_lsb +: 4];

    // Decimal magnitude of the edited digits for the reset check
    assign magnitude = 14'(edit_q[15:12]) * 14'h3E8 + 14'(edit_q[11:8]) * 14'h064
                     + 14'(edit_q[7:4]) * 14'h00A + {10'h000, edit_q[3:0]};
    assign reset_value = ~edit_q[keypad_pkg::FLD_NEG]
                       & (magnitude >= keypad_pkg::RESET_LO)
                       & (magnitude <= keypad_pkg::RESET_HI);

    // Registration happens only on enter inside an active, still legal edit
    assign commit = (state_q == keypad_pkg::EDIT_ACTIVE) & press[keypad_pkg::K_ENTER]
                  & editable & ~navigate;

    // Row and column selection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_q <= 4'h0;
            col_q <= 4'h0;
        end else if (jump) begin
            row_q <= 4'h0;
            col_q <= 4'h0;
        end else begin
            if (press[keypad_pkg::K_ROW]) begin
                row_q <= (row_q == keypad_pkg::LAST_INDEX) ? 4'h0 : row_q + 4'h1;
            end
            if (press[keypad_pkg::K_COL]) begin
                col_q <= (col_q == keypad_pkg::LAST_INDEX) ? 4'h0 : col_q + 4'h1;
            end
        end
    end

    // Edit state, cursor and edit buffer; leaving the field drops the edit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= keypad_pkg::EDIT_IDLE;
            cursor_q <= 2'h0;
            edit_q <= keypad_pkg::FACTORY_DEFAULT;
        end else if (navigate | ~editable) begin
            state_q <= keypad_pkg::EDIT_IDLE;
            cursor_q <= 2'h0;
        end else begin
            unique case (state_q)
                keypad_pkg::EDIT_IDLE: begin
                    if (press[keypad_pkg::K_RIGHT] & ~dp_combo) begin
                        state_q <= keypad_pkg::EDIT_ACTIVE;
                        cursor_q <= 2'h0;
                        edit_q <= field_q[cur_idx];
                    end
                end
                keypad_pkg::EDIT_ACTIVE: begin
                    if (press[keypad_pkg::K_ENTER]) begin
                        state_q <= keypad_pkg::EDIT_IDLE;
                        cursor_q <= 2'h0;
                    end else if (dp_combo) begin
                        edit_q[keypad_pkg::FLD_DP_LSB +: 2] <=
                            edit_q[keypad_pkg::FLD_DP_LSB +: 2] + 2'h1;
                    end else if (press[keypad_pkg::K_RIGHT]) begin
                        cursor_q <= (cursor_q == keypad_pkg::LAST_DIGIT) ? 2'h0
                                  : cursor_q + 2'h1;
                    end else if (press[keypad_pkg::K_INC]) begin
                        if (cursor_q == 2'h0 && edit_q[keypad_pkg::FLD_NEG]
                            && cur_digit == 4'h0) begin
                            edit_q[keypad_pkg::FLD_NEG] <= 1'b0;
                        end else begin
                            edit_q[digit_lsb +: 4] <= (cur_digit == keypad_pkg::DIGIT_MAX)
                                ? 4'h0 : cur_digit + 4'h1;
                        end
                    end else if (press[keypad_pkg::K_DEC]) begin
                        if (cursor_q == 2'h0 && ~edit_q[keypad_pkg::FLD_NEG]
                            && cur_digit == 4'h0) begin
                            edit_q[keypad_pkg::FLD_NEG] <= 1'b1;
                        end else begin
                            edit_q[digit_lsb +: 4] <= (cur_digit == 4'h0)
                                ? keypad_pkg::DIGIT_MAX : cur_digit - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Wishbone request decode; a write lands on the edge where ack is seen
    assign bus_take = wb_cyc_i & wb_stb_i & ~ack_q;
    assign bus_write = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    // The gateway may only change fields while no terminal is plugged in
    assign remote_ok = ~local_q & ~lock;

    // Field storage: factory reload beats a key commit, which beats the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < keypad_pkg::NUM_FIELDS; i++) begin
                field_q[i] <= keypad_pkg::FACTORY_DEFAULT;
            end
        end else if (commit && row_q == keypad_pkg::RESET_ROW
                     && col_q == keypad_pkg::RESET_COL && reset_value) begin
            for (int i = 0; i < keypad_pkg::NUM_FIELDS; i++) begin
                field_q[i] <= keypad_pkg::FACTORY_DEFAULT;
            end
        end else if (commit) begin
            field_q[cur_idx] <= edit_q;
        end else if (bus_write && wb_adr_i == keypad_pkg::OFS_FIELD_DATA && remote_ok
                     && field_sel_q < 7'(keypad_pkg::NUM_FIELDS)) begin
            field_q[field_sel_q] <= wb_dat_i[FW-1:0];
        end
    end

    // Factory reload strobe for the rest of the card
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_q <= 1'b0;
        end else begin
            reload_q <= commit & reset_value & (row_q == keypad_pkg::RESET_ROW)
                      & (col_q == keypad_pkg::RESET_COL);
        end
    end

    // Software registers; the tag level has no key path at all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= keypad_pkg::CTRL_RESET;
            tag_q <= keypad_pkg::TAG_RESET;
            field_sel_q <= keypad_pkg::FIELD_SEL_RESET;
        end else if (bus_write) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    if (wb_adr_i == keypad_pkg::OFS_CTRL) begin
                        ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8]
                                          & keypad_pkg::CTRL_WMASK[b*8 +: 8];
                    end
                    if (wb_adr_i == keypad_pkg::OFS_TAG && ~local_q) begin
                        tag_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                    end
                end
            end
            if (wb_adr_i == keypad_pkg::OFS_FIELD_SEL && wb_sel_i[0]) begin
                field_sel_q <= wb_dat_i[6:0];
            end
        end
    end

    // Terminal presence decides who controls the card, in both directions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_q <= 1'b0;
        end else begin
            local_q <= terminal_present_i;
        end
    end

    // Bus address is the weighted sum of the switches that are on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= 6'h00;
        end else begin
            addr_q <= 6'h00;
            for (int s = 0; s < keypad_pkg::SW_COUNT; s++) begin
                if (addr_switch_i[s]) begin
                    addr_q <= addr_q_sum(addr_switch_i);
                end
            end
        end
    end

    // Six binary weights cannot exceed 63, so no range check is needed
    function automatic logic [5:0] addr_q_sum(input logic [5:0] sw);
        logic [5:0] acc;
        acc = 6'h00;
        for (int s = 0; s < keypad_pkg::SW_COUNT; s++) begin
            acc = acc + (sw[s] ? 6'(1 << s) : 6'h00);
        end
        return acc;
    endfunction

    // Flash divider: the phase flips once per half period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_cnt_q <= '0;
            phase_q <= 1'b0;
        end else if (flash_cnt_q == keypad_pkg::FLASH_CNT_W'(FLASH_HALF_CYCLES - 1)) begin
            flash_cnt_q <= '0;
            phase_q <= ~phase_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    // Editable fields flash, read-only and locked ones stay steady
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_q <= 1'b0;
        end else begin
            blink_q <= editable & phase_q;
        end
    end

    // Display shows the edit buffer while editing, else the stored value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shown_q <= keypad_pkg::FACTORY_DEFAULT;
        end else if (state_q == keypad_pkg::EDIT_ACTIVE) begin
            shown_q <= edit_q;
        end else begin
            shown_q <= field_q[cur_idx];
        end
    end

    assign status_word = {10'h000, addr_q, 1'b0, local_q, edit_q[18:17], edit_q[16],
                          state_q, cursor_q, col_q, row_q};
    assign field_word = (field_sel_q < 7'(keypad_pkg::NUM_FIELDS))
                      ? {13'h0000, field_q[field_sel_q]} : 32'h0000_0000;

    // Single wait state: ack follows the request by one edge, then drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_take;
            if (bus_take) begin
                unique case (wb_adr_i)
                    keypad_pkg::OFS_CTRL: rdata_q <= ctrl_q;
                    keypad_pkg::OFS_STATUS: rdata_q <= status_word;
                    keypad_pkg::OFS_FIELD_SEL: rdata_q <= {25'h0000000, field_sel_q};
                    keypad_pkg::OFS_FIELD_DATA: rdata_q <= field_word;
                    keypad_pkg::OFS_TAG: rdata_q <= tag_q;
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;
    assign row_o = row_q;
    assign col_o = col_q;
    assign cursor_o = cursor_q;
    assign editing_o = state_q;
    assign value_digits_o = shown_q[15:0];
    assign minus_o = shown_q[keypad_pkg::FLD_NEG];
    assign dp_o = shown_q[keypad_pkg::FLD_DP_LSB +: 2];
    assign blink_o = blink_q;
    assign local_mode_o = local_q;
    assign dev_addr_o = addr_q;
    assign factory_reload_o = reload_q;

endmodule

// file: panel_operator.sv
// Far-side model: the operator's fingers on the panel keys and the terminal plug.
// Runs on the block's clock; keys come out clean and already debounced.
`timescale 1ns/1ps
module panel_operator (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [5:0] keys_i,
    input wire logic [5:0] held_i,
    input wire logic [3:0] hold_i,
    input wire logic plug_i,
    output logic [5:0] keys_o,
    output logic busy_o,
    output logic terminal_present_o
);
    logic [5:0] keys_q;
    logic [3:0] cnt_q;

    // One press holds keys for hold_i cycles, then lets go so the next press is an edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            keys_q <= 6'h00;
            cnt_q <= 4'h0;
        end else if (go_i && cnt_q == 4'h0) begin
            keys_q <= keys_i;
            cnt_q <= hold_i;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // Released keys fall to the open-contact level, low; held keys stay down
    assign keys_o = held_i | ((cnt_q != 4'h0) ? keys_q : 6'h00);
    assign busy_o = (cnt_q != 4'h0);
    // Presence contact follows the plug at once
    assign terminal_present_o = plug_i;
endmodule

// file: keypad_entry_asserts.sv
// Checker for keypad_entry: bus answer, navigation, cursor and mirrored inputs.
// Bound to keypad_entry; sees its ports only, one clock domain.
`timescale 1ns/1ps
module keypad_entry_asserts #(
    parameter int unsigned FLASH_HALF_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic key_row_i,
    input wire logic key_col_i,
    input wire logic key_right_i,
    input wire logic key_inc_i,
    input wire logic key_enter_i,
    input wire logic [5:0] addr_switch_i,
    input wire logic terminal_present_i,
    input wire logic [3:0] row_o,
    input wire logic [3:0] col_o,
    input wire logic [1:0] cursor_o,
    input wire logic editing_o,
    input wire logic local_mode_o,
    input wire logic [5:0] dev_addr_o,
    input wire logic factory_reload_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Key steps; the jump needs the other navigation key held
    sequence row_press;
        $rose(key_row_i) && !key_col_i;
    endsequence
    sequence col_press;
        $rose(key_col_i) && !key_row_i;
    endsequence
    sequence both_press;
        ($rose(key_row_i) && key_col_i) || ($rose(key_col_i) && key_row_i);
    endsequence
    sequence edit_start;
        !editing_o && $rose(key_right_i) && !key_inc_i && !key_row_i && !key_col_i;
    endsequence
    sequence edit_step;
        editing_o && $rose(key_right_i) && !key_inc_i && !key_row_i && !key_col_i;
    endsequence

    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over one cycle");
    row_step_a: assert property (
        row_press |=> col_o == $past(col_o)
            && row_o == (($past(row_o) == 4'h9) ? 4'h0 : $past(row_o) + 4'h1))
        else $error("row step wrong");
    col_step_a: assert property (
        col_press |=> row_o == $past(row_o)
            && col_o == (($past(col_o) == 4'h9) ? 4'h0 : $past(col_o) + 4'h1))
        else $error("column step wrong");
    jump_home_a: assert property (both_press |=> row_o == 4'h0 && col_o == 4'h0)
        else $error("joint press did not reach home field");
    edit_first_a: assert property (edit_start |=> !editing_o || cursor_o == 2'h0)
        else $error("edit did not start at leftmost digit");
    cursor_step_a: assert property (
        edit_step |=> !editing_o || cursor_o == $past(cursor_o) + 2'h1)
        else $error("cursor step wrong");
    point_shift_a: assert property (
        editing_o && $rose(key_right_i) && key_inc_i && $past(key_inc_i)
            |=> !editing_o || cursor_o == $past(cursor_o))
        else $error("cursor moved during point shift");
    enter_leave_a: assert property (editing_o && $rose(key_enter_i) |=> !editing_o)
        else $error("enter did not end edit");
    addr_mirror_a: assert property (!rst_i |=> dev_addr_o == $past(addr_switch_i))
        else $error("device address differs from switch sum");
    local_take_a: assert property (terminal_present_i |=> local_mode_o)
        else $error("terminal did not take control");
    remote_back_a: assert property (!terminal_present_i |=> !local_mode_o)
        else $error("control not handed back");
    reload_pulse_a: assert property (factory_reload_o |=> !factory_reload_o)
        else $error("reload pulse too long");
endmodule

bind keypad_entry keypad_entry_asserts #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .key_row_i(key_row_i), .key_col_i(key_col_i),
    .key_right_i(key_right_i), .key_inc_i(key_inc_i), .key_enter_i(key_enter_i),
    .addr_switch_i(addr_switch_i), .terminal_present_i(terminal_present_i),
    .row_o(row_o), .col_o(col_o), .cursor_o(cursor_o), .editing_o(editing_o),
    .local_mode_o(local_mode_o), .dev_addr_o(dev_addr_o),
    .factory_reload_o(factory_reload_o)
);

// file: keypad_entry_tb.sv
// Testbench for keypad_entry: navigation and switch rows, then edit, lock,
// flash, terminal hand-over and factory reload. Needs panel_operator.
`timescale 1ns/1ps
module keypad_entry_tb;
    typedef struct {logic [5:0] keys; int reps; logic [5:0] sw; logic [15:0] exp;} nav_t;
    localparam logic [5:0] KR = 6'h01, KC = 6'h02, KT = 6'h04, KI = 6'h08;
    localparam logic [5:0] KD = 6'h10, KE = 6'h20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0, go = 1'b0, plug = 1'b0, seen = 1'b0;
    logic [3:0] sel = 4'hF, hold = 4'h2, row, col;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, dat;
    logic [5:0] keys = 6'h00, held = 6'h00, sw = 6'h00, k, dev;
    logic ack, busy, tp, edit, minus, blink, lmode, reload;
    logic [1:0] cur, dp;
    logic [15:0] val;
    int n_fail = 0, num_checks = 0, cycles = 0, n;
    // Rows give keys, repeats, switches and expected {row, col, address}
    nav_t rows[6] = '{'{KR, 3, 6'h0A, 16'h300A}, '{KC, 2, 6'h3F, 16'h323F},
        '{KR | KC, 1, 6'h00, 16'h0000}, '{KR, 9, 6'h01, 16'h9001},
        '{KR, 1, 6'h20, 16'h0020}, '{KC, 10, 6'h15, 16'h0015}};

    keypad_entry #(.FLASH_HALF_CYCLES(4)) i_keypad_entry (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
        .key_row_i(k[0]), .key_col_i(k[1]), .key_right_i(k[2]), .key_inc_i(k[3]),
        .key_dec_i(k[4]), .key_enter_i(k[5]), .addr_switch_i(sw),
        .terminal_present_i(tp), .row_o(row), .col_o(col), .cursor_o(cur),
        .editing_o(edit), .value_digits_o(val), .minus_o(minus), .dp_o(dp),
        .blink_o(blink), .local_mode_o(lmode), .dev_addr_o(dev), .factory_reload_o(reload));
    panel_operator i_panel_operator (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .keys_i(keys),
        .held_i(held), .hold_i(hold), .plug_i(plug), .keys_o(k), .busy_o(busy),
        .terminal_present_o(tp));

    // Clock, 25 ns period
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Hang guard and reload pulse catcher
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (reload === 1'b1) seen <= 1'b1;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Single Wishbone cycle; request stands until ack is seen at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask

    // Press keys reps times through the operator model, then let outputs settle
    task automatic press(input logic [5:0] ks, input int reps);
        for (int r = 0; r < reps; r++) begin
            go <= 1'b1;
            keys <= ks;
            @(posedge clk_i);
            go <= 1'b0;
            do @(negedge clk_i); while (busy === 1'b1);
            @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
    endtask

    // Count flash toggles over twenty cycles
    task automatic blinks(output int c);
        logic p;
        c = 0;
        p = blink;
        repeat (20) begin
            @(negedge clk_i);
            if (blink !== p) c++;
            p = blink;
        end
        @(posedge clk_i);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, keypad_pkg::CTRL_RESET, "ctrl reset");
        bus(1'b1, 8'h14, 32'hFFFF_FFFF);
        bus(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0, "unmapped");
        // Rows one and two stand for a cascade pair on distinct addresses
        foreach (rows[i]) begin
            sw <= rows[i].sw;
            press(rows[i].keys, rows[i].reps);
            check(32'({row, col}), 32'(rows[i].exp[15:8]), "row col");
            check(32'(dev), 32'(rows[i].exp[5:0]), "address");
        end
        blinks(n);
        check(32'(n), 32'h0, "read-only flash");
        bus(1'b1, 8'h08, 32'd10);
        bus(1'b1, 8'h0C, 32'h0000_1234);
        press(KR, 1);
        blinks(n);
        check(32'(n > 0), 32'h1, "editable flash");
        press(KT, 1);
        check(32'({edit, cur, val}), 32'h4_1234, "edit start");
        for (int i = 1; i < 5; i++) begin
            press(KT, 1);
            check(32'(cur), 32'(i % 4), "cursor");
        end
        press(KI, 1);
        check(32'(val), 32'h2234, "inc");
        press(KD, 1);
        check(32'(val), 32'h1234, "dec");
        held <= KI;
        press(KT, 1);
        held <= 6'h00;
        check(32'({cur, dp, val}), 32'h1_2234, "point shift");
        press(KD, 3);
        check(32'({minus, val}), 32'h1_0234, "minus");
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0015_1C01, "status");
        bus(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0000_1234, "old value kept");
        press(KE, 1);
        bus(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0003_0234, "registered");
        hold <= 4'h6;
        bus(1'b1, 8'h00, keypad_pkg::CTRL_RESET | 32'h1);
        press(KT, 1);
        check(32'(edit), 32'h0, "locked edit");
        blinks(n);
        check(32'(n), 32'h0, "locked flash");
        bus(1'b1, 8'h0C, 32'h0000_0999);
        bus(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0003_0234, "locked write");
        bus(1'b1, 8'h00, keypad_pkg::CTRL_RESET);
        bus(1'b1, 8'h10, 32'hA5A5_0F0F);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'hA5A5_0F0F, "tag");
        plug <= 1'b1;
        repeat (3) @(posedge clk_i);
        check(32'(lmode), 32'h1, "local");
        bus(1'b1, 8'h10, 32'h0000_0000);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'hA5A5_0F0F, "tag refused in local");
        plug <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(32'(lmode), 32'h0, "remote");
        hold <= 4'h2;
        bus(1'b1, 8'h08, 32'd95);
        bus(1'b1, 8'h0C, 32'h0000_0675);
        press(KR, 8);
        press(KC, 5);
        press(KT, 1);
        press(KE, 1);
        check(32'(seen), 32'h1, "reload pulse");
        bus(1'b1, 8'h08, 32'd10);
        bus(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0, "factory value");
        stop_test();
    end
endmodule
